// *** core/spi_error_flags_and_wakeup.sv ***
// Serial port flags, errors, interrupt merge and halt/wait wake-up
`timescale 1ns/1ps
`default_nettype none
`include "spi_err_map.svh"

module spi_error_flags_and_wakeup
    import spi_err_pkg::*;
#(
    parameter int FIFO_DEPTH = `RX_FIFO_DEPTH,
    parameter int HALF_DIV   = `MASTER_HALF_DIV
) (
    input  wire logic  i_clock,
    input  wire logic  i_rst,
    input  wire logic  i_sck_pin,
    input  wire logic  i_mosi_pin,
    input  wire logic  i_miso_pin,
    input  wire logic  i_ss_pin_n,
    input  wire logic  i_soft_select_mode,
    input  wire logic  i_soft_select_level,
    input  wire logic  i_output_disable,
    input  wire logic  i_cr_write,
    input  wire byte_t i_cr_wdata,
    input  wire logic  i_csr_read,
    input  wire logic  i_dr_write,
    input  wire byte_t i_dr_wdata,
    input  wire logic  i_dr_read,
    input  wire logic  i_cpu_irq_mask,
    input  wire logic  i_wait_mode,
    input  wire logic  i_halt_mode,
    output byte_t      o_control,
    output byte_t      o_status,
    output byte_t      o_rx_data,
    output logic       o_irq,
    output logic       o_wake_wait,
    output logic       o_wake_halt,
    output logic       o_halt_recover,
    output logic       o_sck,
    output logic       o_sck_oe,
    output logic       o_mosi,
    output logic       o_mosi_oe,
    output logic       o_miso,
    output logic       o_miso_oe
);
    // Pin synchronisers, two stages per input
    logic [3:0] pins;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;

    assign pins = {i_ss_pin_n, i_miso_pin, i_mosi_pin, i_sck_pin};

    for (genvar g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                sync1_q[g] <= 1'b1;
                sync2_q[g] <= 1'b1;
            end else begin
                sync1_q[g] <= pins[g];
                sync2_q[g] <= sync1_q[g];
            end
        end
    end

    wire sck_s  = sync2_q[0];
    wire mosi_s = sync2_q[1];
    wire miso_s = sync2_q[2];
    wire ss_s_n = sync2_q[3];

    // Control register and flags
    byte_t        cr_q;
    byte_t        rx_buf_q;
    logic         done_q;
    logic         wclash_q;
    logic         ovr_q;
    logic         mode_fault_flag_q;
    logic         done_arm_q;
    logic         wclash_arm_q;
    logic         mode_fault_flag_arm_q;
    logic         wake_armed_q;
    power_state_t pwr_q;
    power_state_t pwr_d;

    wire irq_en    = cr_q[`CR_IRQ_EN];
    wire port_en   = cr_q[`CR_PORT_EN];
    wire master    = cr_q[`CR_MASTER];
    wire halted    = (pwr_q == PWR_HALTED);

    wire ss_int_n  = i_soft_select_mode ? i_soft_select_level : ss_s_n;
    wire ss_low    = !ss_int_n;

    // Shift engine and receive queue
    logic  sh_busy;
    logic  sh_rx_valid;
    byte_t sh_rx_data;
    logic  sh_sck;
    logic  sh_dout;
    logic  fifo_in_ready;
    logic  fifo_out_valid;
    byte_t fifo_out_data;

    // halt freezes the port unless a slave wake was armed
    wire sh_run    = !halted || (!master && wake_armed_q);

    // write during a transfer is dropped and flagged
    wire clash     = i_dr_write && sh_busy;
    // Writes stay inhibited while done is set until the status read arms the clear
    wire dr_load   = i_dr_write && !sh_busy && (!done_q || done_arm_q);

    // bytes reach software only through the buffer
    wire pop_ready = !halted;
    wire pop       = fifo_out_valid && pop_ready;
    // a byte that finds the queue full is lost
    wire lost      = sh_rx_valid && !fifo_in_ready;

    spi_shifter #(
        .HALF_DIV (HALF_DIV)
    ) u_shifter (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_run       (sh_run),
        .i_master    (master),
        .i_cpol      (cr_q[`CR_CPOL]),
        .i_cpha      (cr_q[`CR_CPHA]),
        .i_ss_low    (ss_low),
        .i_sck       (sck_s),
        .i_din       (master ? miso_s : mosi_s),
        .i_load      (dr_load),
        .i_load_data (i_dr_wdata),
        .o_sck_level (sh_sck),
        .o_dout      (sh_dout),
        .o_busy      (sh_busy),
        .o_rx_valid  (sh_rx_valid),
        .o_rx_data   (sh_rx_data)
    );

    spi_rx_fifo #(
        .WIDTH (`BYTE_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_valid (sh_rx_valid),
        .o_ready (fifo_in_ready),
        .i_data  (sh_rx_data),
        .o_valid (fifo_out_valid),
        .i_ready (pop_ready),
        .o_data  (fifo_out_data)
    );

    wire mode_fault_flag_set   = master && ss_low && !halted;
    wire mode_fault_flag_clear = mode_fault_flag_arm_q && i_cr_write;
    wire done_set   = pop && !done_q;
    wire done_clear = done_arm_q && (i_dr_read || i_dr_write);
    // byte completing on a set done flag, or a byte lost to a full queue
    wire ovr_set    = (pop && done_q) || lost;
    wire wcl_clear  = wclash_arm_q && i_dr_read;

    // a standing fault refuses the set of enable and master
    wire   lock_bits = mode_fault_flag_q && !mode_fault_flag_clear;
    wire byte_t cr_keep = 8'hFF & ~(lock_bits ?
        (8'h01 << `CR_PORT_EN) | (8'h01 << `CR_MASTER) : 8'h00);
    wire byte_t cr_wr   = (i_cr_wdata & cr_keep) | (cr_q & ~cr_keep & i_cr_wdata);
    wire byte_t cr_next = i_cr_write ? cr_wr : cr_q;
    wire byte_t cr_d    = mode_fault_flag_set ?
        cr_next & ~((8'h01 << `CR_PORT_EN) | (8'h01 << `CR_MASTER)) : cr_next;

    wire irq_d = irq_en && !i_cpu_irq_mask && (done_q || mode_fault_flag_q || ovr_q);
    // only a slave transfer with select low at entry wakes halt
    wire wake_halt_d = halted && wake_armed_q && !master && fifo_out_valid
                       && irq_en && !i_cpu_irq_mask;

    // Power state
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            PWR_RUN: begin
                if (i_halt_mode) pwr_d = PWR_HALTED;
            end
            PWR_HALTED: begin
                // slave needs one more transfer after waking
                if (!i_halt_mode) pwr_d = master ? PWR_RUN : PWR_RECOVER;
            end
            PWR_RECOVER: begin
                if (i_halt_mode) pwr_d = PWR_HALTED;
                // Bytes queued during halt do not count; only a fresh transfer does
                else if (sh_rx_valid || master) pwr_d = PWR_RUN;
            end
            default: pwr_d = PWR_RUN;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pwr_q        <= PWR_RUN;
            wake_armed_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            // select level caught as halt begins
            if (!halted && pwr_d == PWR_HALTED) wake_armed_q <= ss_low;
        end
    end

    // Flags, registers frozen while halted, except overrun setting
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cr_q         <= `CR_RESET;
            rx_buf_q     <= 8'h00;
            done_q       <= 1'b0;
            wclash_q     <= 1'b0;
            ovr_q        <= 1'b0;
            mode_fault_flag_q       <= 1'b0;
            done_arm_q   <= 1'b0;
            wclash_arm_q <= 1'b0;
            mode_fault_flag_arm_q   <= 1'b0;
        end else if (!halted) begin
            cr_q <= cr_d;
            // first byte kept once done is set
            if (done_set) rx_buf_q <= fifo_out_data;
            if (done_set) done_q <= 1'b1;
            else if (done_clear) done_q <= 1'b0;
            if (i_csr_read && done_q) done_arm_q <= 1'b1;
            else if (done_clear) done_arm_q <= 1'b0;
            if (clash) wclash_q <= 1'b1;
            else if (wcl_clear) wclash_q <= 1'b0;
            if (i_csr_read && wclash_q) wclash_arm_q <= 1'b1;
            else if (wcl_clear) wclash_arm_q <= 1'b0;
            if (ovr_set) ovr_q <= 1'b1;
            else if (i_csr_read) ovr_q <= 1'b0;
            // fault cleared by status read then control write
            if (mode_fault_flag_set) mode_fault_flag_q <= 1'b1;
            else if (mode_fault_flag_clear) mode_fault_flag_q <= 1'b0;
            if (i_csr_read && mode_fault_flag_q) mode_fault_flag_arm_q <= 1'b1;
            else if (mode_fault_flag_clear) mode_fault_flag_arm_q <= 1'b0;
        end else if (ovr_set) begin
            // bytes lost in halt still mark overrun
            ovr_q <= 1'b1;
        end
    end

    // Registered outputs
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_control      <= 8'h00;
            o_status       <= 8'h00;
            o_rx_data      <= 8'h00;
            o_irq          <= 1'b0;
            o_wake_wait    <= 1'b0;
            o_wake_halt    <= 1'b0;
            o_halt_recover <= 1'b0;
            o_sck          <= 1'b0;
            o_sck_oe       <= 1'b0;
            o_mosi         <= 1'b0;
            o_mosi_oe      <= 1'b0;
            o_miso         <= 1'b0;
            o_miso_oe      <= 1'b0;
        end else begin
            o_control <= cr_q;
            o_status  <= {done_q, wclash_q, ovr_q, mode_fault_flag_q, 1'b0,
                          i_output_disable, i_soft_select_mode, i_soft_select_level};
            o_rx_data <= rx_buf_q;
            o_irq     <= irq_d;
            o_wake_wait    <= i_wait_mode && irq_d;
            o_wake_halt    <= wake_halt_d;
            o_halt_recover <= (pwr_q == PWR_RECOVER);
            o_sck          <= sh_sck;
            o_mosi         <= sh_dout;
            o_miso         <= sh_dout;
            // no drive without the port enable
            o_sck_oe  <= port_en && master;
            o_mosi_oe <= port_en && master && !i_output_disable;
            o_miso_oe <= port_en && !master && ss_low && !i_output_disable;
        end
    end

endmodule : spi_error_flags_and_wakeup

`default_nettype wire

// *** core/spi_err_map.svh ***
// Bit positions, reset values and timing counts of the serial port flag logic
`ifndef SPI_ERR_MAP_SVH
`define SPI_ERR_MAP_SVH

`define CR_IRQ_EN        7
`define CR_PORT_EN       6
`define CR_MASTER        4
`define CR_CPOL          3
`define CR_CPHA          2
`define CR_RESET         8'h00

`define CSR_DONE         7
`define CSR_WCLASH       6
`define CSR_OVERRUN      5
`define CSR_MODE_FAULT   4
`define CSR_OUT_DIS      2
`define CSR_SOFT_MODE    1
`define CSR_SOFT_LEVEL   0

`define BYTE_BITS        8
`define RX_FIFO_DEPTH    16
`define MASTER_HALF_DIV  2

`endif

// *** core/spi_err_pkg.sv ***
// Types shared by the serial port flag logic
package spi_err_pkg;

    typedef logic [7:0] byte_t;

    // Gray along run -> halted -> recover
    typedef enum logic [1:0] {
        PWR_RUN     = 2'b00,
        PWR_HALTED  = 2'b01,
        PWR_RECOVER = 2'b11
    } power_state_t;

endpackage : spi_err_pkg

// *** core/spi_rx_fifo.sv ***
// Receive byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module spi_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("spi_rx_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;

    wire full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push  = i_valid && !full;
    wire pop   = i_ready && !empty;

    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem[rd_q[AW-1:0]];

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
        end
    end

endmodule : spi_rx_fifo

`default_nettype wire

// *** core/spi_shifter.sv ***
// Byte shift engine for master and slave, all four clock modes
`timescale 1ns/1ps
`default_nettype none
`include "spi_err_map.svh"

module spi_shifter
    import spi_err_pkg::*;
#(
    parameter int HALF_DIV = `MASTER_HALF_DIV
) (
    input  wire logic  i_clock,
    input  wire logic  i_rst,
    input  wire logic  i_run,
    input  wire logic  i_master,
    input  wire logic  i_cpol,
    input  wire logic  i_cpha,
    input  wire logic  i_ss_low,
    input  wire logic  i_sck,
    input  wire logic  i_din,
    input  wire logic  i_load,
    input  wire byte_t i_load_data,
    output logic       o_sck_level,
    output logic       o_dout,
    output logic       o_busy,
    output logic       o_rx_valid,
    output byte_t      o_rx_data
);
    localparam int DW = $clog2(HALF_DIV + 1);

    if (HALF_DIV < 1) begin : g_bad_div
        $error("spi_shifter: HALF_DIV must be at least 1");
    end

    byte_t         shift_q;
    logic          rbit_q;
    logic [3:0]    cnt_q;
    logic          prev_q;
    logic          phase_q;
    logic          active_q;
    logic [DW-1:0] div_q;

    // Slave edges are only seen while selected and not frozen
    wire norm    = i_sck ^ i_cpol;
    wire sl_ok   = !i_master && i_ss_low && i_run;
    wire tick    = i_master && active_q && i_run && (div_q == DW'(HALF_DIV - 1));
    wire lead    = (sl_ok && norm && !prev_q) || (tick && !phase_q);
    wire trail   = (sl_ok && !norm && prev_q) || (tick && phase_q);
    wire sample  = i_cpha ? trail : lead;
    wire in_bit  = i_cpha ? i_din : rbit_q;
    wire last    = trail && (cnt_q == 4'h7);
    wire byte_t next_sr = {shift_q[6:0], in_bit};

    assign o_busy      = active_q || (cnt_q != 4'h0);
    assign o_sck_level = i_cpol ^ phase_q;
    assign o_dout      = shift_q[7];

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            shift_q    <= 8'h00;
            rbit_q     <= 1'b0;
            cnt_q      <= 4'h0;
            prev_q     <= 1'b0;
            phase_q    <= 1'b0;
            active_q   <= 1'b0;
            div_q      <= '0;
            o_rx_valid <= 1'b0;
            o_rx_data  <= 8'h00;
        end else begin
            prev_q     <= norm;
            o_rx_valid <= last;
            if (i_load && !o_busy) begin
                shift_q  <= i_load_data;
                active_q <= i_master;
                phase_q  <= 1'b0;
                div_q    <= '0;
            end
            if (i_master && active_q && i_run) begin
                div_q <= tick ? '0 : div_q + 1'b1;
            end
            if (tick) phase_q <= !phase_q;
            if (sample) rbit_q <= i_din;
            if (trail) begin
                shift_q <= next_sr;
                cnt_q   <= last ? 4'h0 : cnt_q + 4'h1;
            end
            if (last) begin
                o_rx_data <= next_sr;
                active_q  <= 1'b0;
            end
            if (!i_master && !i_ss_low) cnt_q <= 4'h0;
        end
    end

endmodule : spi_shifter

`default_nettype wire

// *** bench/spi_err_checker.sv ***
// Assertions on the flag, request and halt behaviour of the serial port
`timescale 1ns/1ps
`default_nettype none

module spi_err_checker
    import spi_err_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int HALF_DIV   = 2
) (
    input wire logic  i_clock,
    input wire logic  i_rst,
    input wire logic  i_cr_write,
    input wire logic  i_csr_read,
    input wire logic  i_dr_write,
    input wire logic  i_cpu_irq_mask,
    input wire logic  i_halt_mode,
    input wire byte_t o_control,
    input wire byte_t o_status,
    input wire logic  o_irq,
    input wire logic  o_wake_halt,
    input wire logic  o_halt_recover
);
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // Write clash is left out on purpose: it is status only
    wire irq_cause = o_control[7] & ~i_cpu_irq_mask & (o_status[7] | o_status[5] | o_status[4]);

    irq_on_a: assert property (irq_cause [*3] |-> o_irq)
        else $error("request missing while an enabled flag stands");
    irq_off_a: assert property (!irq_cause [*3] |-> !o_irq)
        else $error("request raised with no enabled flag");
    fault_drop_a: assert property ($rose(o_status[4]) |-> ##[0:1] (!o_control[6] && !o_control[4]))
        else $error("mode fault left enable or master set");
    fault_master_a: assert property ($rose(o_status[4]) |-> $past(o_control[4]) || $past(o_control[4], 2))
        else $error("mode fault raised while slave");
    fault_clear_a: assert property ($fell(o_status[4]) |-> $past(i_cr_write, 2) || $past(i_cr_write, 3))
        else $error("mode fault cleared without control write");
    enable_refuse_a: assert property ($rose(o_control[6]) |-> ##[0:1] !o_status[4])
        else $error("port enable set while mode fault stands");
    ovr_clear_a: assert property ($fell(o_status[5]) |-> $past(i_csr_read, 2) || $past(i_csr_read, 3))
        else $error("overrun cleared without status read");
    clash_set_a: assert property ($rose(o_status[6]) |-> $past(i_dr_write, 2) || $past(i_dr_write, 3))
        else $error("write clash without data write");
    halt_freeze_a: assert property (i_halt_mode [*3] |-> $stable(o_control))
        else $error("control changed while halted");
    halt_wake_a: assert property (o_wake_halt && $past(i_halt_mode, 2) |-> o_control[7] && !o_control[4])
        else $error("halt wake without enabled slave");

    cover property ($rose(o_status[4]));
    cover property ($rose(o_status[5]));
    cover property ($rose(o_status[6]));
    cover property ($rose(o_halt_recover));
endmodule : spi_err_checker

bind spi_error_flags_and_wakeup spi_err_checker #(.FIFO_DEPTH(FIFO_DEPTH), .HALF_DIV(HALF_DIV))
    chk_i (.i_clock(i_clock), .i_rst(i_rst), .i_cr_write(i_cr_write), .i_csr_read(i_csr_read),
           .i_dr_write(i_dr_write), .i_cpu_irq_mask(i_cpu_irq_mask), .i_halt_mode(i_halt_mode),
           .o_control(o_control), .o_status(o_status), .o_irq(o_irq),
           .o_wake_halt(o_wake_halt), .o_halt_recover(o_halt_recover));

`default_nettype wire

// *** bench/spi_far_master.sv ***
// Behavioural far-side master clocking one byte per request, clock mode 0
`timescale 1ns/1ps
`default_nettype none

module spi_far_master (
    input  wire logic       i_go,
    input  wire logic [7:0] i_tx,
    input  wire logic       i_miso,
    output logic            o_sck,
    output logic            o_mosi,
    output logic            o_ss_n,
    output logic [7:0]      o_rx,
    output logic            o_busy
);
    initial begin
        o_sck  = 1'b0;
        o_mosi = 1'b1;
        o_ss_n = 1'b1;
        o_rx   = 8'h00;
        o_busy = 1'b0;
    end

    always @(posedge i_go) begin
        o_busy = 1'b1;
        o_ss_n = 1'b0;
        // Off the sampling grid so pin changes never race a clock edge
        #162;
        for (int b = 7; b >= 0; b--) begin
            o_mosi = i_tx[b];
            #100;
            o_sck   = 1'b1;
            o_rx[b] = i_miso;
            #100;
            o_sck = 1'b0;
        end
        #100;
        o_ss_n = 1'b1;
        // A released line flips so a stale bit never reads as data
        o_mosi = ~o_mosi;
        #300;
        o_busy = 1'b0;
    end
endmodule : spi_far_master

`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the serial port flag and wake-up logic
`timescale 1ns/1ps
`default_nettype none

module testbench
    import spi_err_pkg::*;
;
    localparam int CR = 0, CSR = 1, DWR = 2, DRD = 3;
    logic       i_clock = 1'b0, i_rst = 1'b1;
    logic       cr_wr = 1'b0, csr_rd = 1'b0, dr_wr = 1'b0, dr_rd = 1'b0;
    byte_t      cr_d = 8'h00, dr_d = 8'h00, far_tx = 8'h00;
    logic       soft_mode = 1'b0, soft_level = 1'b0, irq_mask = 1'b0;
    logic       wait_md = 1'b0, halt_md = 1'b0, go = 1'b0;
    wire byte_t control, status, rx_data, far_rx;
    wire logic  irq, wake_wait, wake_halt, recover, miso, sck, mosi, ss_n, far_busy;
    int         errors = 0, checks_done = 0;

    always #12.5 i_clock = ~i_clock;

    spi_error_flags_and_wakeup dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_sck_pin(sck), .i_mosi_pin(mosi),
        .i_miso_pin(1'b1), .i_ss_pin_n(ss_n), .i_soft_select_mode(soft_mode),
        .i_soft_select_level(soft_level), .i_output_disable(1'b0), .i_cr_write(cr_wr),
        .i_cr_wdata(cr_d), .i_csr_read(csr_rd), .i_dr_write(dr_wr), .i_dr_wdata(dr_d),
        .i_dr_read(dr_rd), .i_cpu_irq_mask(irq_mask), .i_wait_mode(wait_md),
        .i_halt_mode(halt_md), .o_control(control), .o_status(status), .o_rx_data(rx_data),
        .o_irq(irq), .o_wake_wait(wake_wait), .o_wake_halt(wake_halt),
        .o_halt_recover(recover), .o_sck(), .o_sck_oe(), .o_mosi(), .o_mosi_oe(),
        .o_miso(miso), .o_miso_oe());

    spi_far_master far (.i_go(go), .i_tx(far_tx), .i_miso(miso), .o_sck(sck),
        .o_mosi(mosi), .o_ss_n(ss_n), .o_rx(far_rx), .o_busy(far_busy));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        #1;
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // Idle cycles after the strobe let its effect reach the status view
    task automatic acc(input int k, input byte_t d);
        @(posedge i_clock);
        cr_wr  <= (k == CR);
        csr_rd <= (k == CSR);
        dr_wr  <= (k == DWR);
        dr_rd  <= (k == DRD);
        cr_d   <= d;
        dr_d   <= d;
        @(posedge i_clock);
        {cr_wr, csr_rd, dr_wr, dr_rd} <= 4'h0;
        repeat (2) @(posedge i_clock);
    endtask : acc

    task automatic xfer(input byte_t tx);
        int n;
        @(posedge i_clock);
        far_tx <= tx;
        go     <= 1'b1;
        @(posedge i_clock);
        go <= 1'b0;
        for (n = 0; n < 300 && far_busy; n++) @(posedge i_clock);
    endtask : xfer

    task automatic final_report;
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        chk(control, 8'h00);
        chk(status & 8'hF0, 8'h00);
        acc(CR, 8'hC0);
        acc(DWR, 8'hA5);
        @(posedge i_clock);
        wait_md <= 1'b1;
        xfer(8'h3C);
        chk(far_rx, 8'hA5);
        chk(status & 8'hF0, 8'h80);
        chk({7'h00, irq}, 8'h01);
        chk({7'h00, wake_wait}, 8'h01);
        chk(rx_data, 8'h3C);
        @(posedge i_clock);
        irq_mask <= 1'b1;
        wait_md  <= 1'b0;
        repeat (3) @(posedge i_clock);
        chk({7'h00, irq}, 8'h00);
        @(posedge i_clock);
        irq_mask <= 1'b0;
        acc(CSR, 8'h00);
        acc(DRD, 8'h00);
        chk(status & 8'hF0, 8'h00);
        chk({7'h00, irq}, 8'h00);
        xfer(8'h11);
        chk(far_rx, 8'h3C);
        xfer(8'h22);
        chk(status & 8'hE0, 8'hA0);
        chk(rx_data, 8'h11);
        acc(CSR, 8'h00);
        chk(status & 8'h20, 8'h00);
        acc(DRD, 8'h00);
        fork
            xfer(8'h99);
            begin
                repeat (40) @(posedge i_clock);
                acc(DWR, 8'h77);
                chk(status & 8'h40, 8'h40);
                chk({7'h00, irq}, 8'h00);
            end
        join
        chk(far_rx, 8'h22);
        acc(CSR, 8'h00);
        acc(DRD, 8'h00);
        chk(status & 8'hF0, 8'h00);
        @(posedge i_clock);
        soft_mode  <= 1'b1;
        soft_level <= 1'b1;
        acc(CR, 8'hD0);
        chk(control, 8'hD0);
        @(posedge i_clock);
        soft_level <= 1'b0;
        repeat (4) @(posedge i_clock);
        chk(status & 8'h10, 8'h10);
        chk(control, 8'h80);
        chk({7'h00, irq}, 8'h01);
        repeat (8) @(posedge i_clock);
        chk(status & 8'h10, 8'h10);
        @(posedge i_clock);
        soft_level <= 1'b1;
        acc(CR, 8'hD0);
        chk(control, 8'h80);
        chk(status & 8'h10, 8'h10);
        acc(CSR, 8'h00);
        acc(CR, 8'hD0);
        chk(status & 8'h10, 8'h00);
        chk(control, 8'hD0);
        acc(CR, 8'hC0);
        @(posedge i_clock);
        soft_level <= 1'b0;
        @(posedge i_clock);
        halt_md <= 1'b1;
        xfer(8'h5A);
        chk({7'h00, wake_halt}, 8'h01);
        xfer(8'h6B);
        @(posedge i_clock);
        halt_md <= 1'b0;
        repeat (6) @(posedge i_clock);
        chk(status & 8'hA0, 8'hA0);
        chk(rx_data, 8'h5A);
        chk({7'h00, recover}, 8'h01);
        final_report;
    end

    // About thirty times the expected run length
    initial begin
        repeat (20000) @(posedge i_clock);
        errors++;
        final_report;
    end
endmodule : testbench

`default_nettype wire
